// ===== src/qst_pkg.sv
// Shared constants, command codes and helpers of the questionable status tree
package qst_pkg;

    localparam int REG_W       = 16;
    localparam int NUM_REGS    = 5;
    localparam int SEL_W       = 3;
    localparam int OP_W        = 4;
    localparam int ERR_NUM_W   = 16;
    localparam int ERR_DESC_W  = 8;
    localparam int ENTRY_W     = ERR_NUM_W + ERR_DESC_W;
    localparam int QUEUE_DEPTH = 8;
    localparam int QUEUE_PTR_W = 3;
    localparam int QUEUE_CNT_W = 4;

    localparam logic [REG_W-1:0] ALL_ONES  = 16'hFFFF;
    localparam logic [REG_W-1:0] ALL_ZEROS = 16'h0000;

    // Reset values of the filter and mask parts
    localparam logic [REG_W-1:0] ENA_RST  = 16'h0000;
    localparam logic [REG_W-1:0] PTR_RST  = 16'hFFFF;
    localparam logic [REG_W-1:0] NTR_RST  = 16'h0000;
    localparam logic [REG_W-1:0] OPER_RST = 16'h0000;
    localparam logic             QENA_RST = 1'b1;

    // Summary bit positions in the parent registers
    localparam int INTEG_SUM_BIT    = 9;
    localparam int LIM1_SUM_BIT     = 10;
    localparam int INTEG_HW_SUM_BIT = 1;
    localparam int LIM2_SUM_BIT     = 0;

    localparam logic signed [ERR_NUM_W-1:0] NO_ERROR_NUM  = 16'sh0000;
    localparam logic [ERR_DESC_W-1:0]       NO_ERROR_DESC = 8'h00;
    localparam logic [QUEUE_PTR_W-1:0]      QPTR_ZERO     = 3'h0;
    localparam logic [QUEUE_PTR_W-1:0]      QPTR_ONE      = 3'h1;
    localparam logic [QUEUE_CNT_W-1:0]      QCNT_ZERO     = 4'h0;
    localparam logic [QUEUE_CNT_W-1:0]      QCNT_ONE      = 4'h1;
    localparam logic [QUEUE_CNT_W-1:0]      QCNT_FULL     = 4'h8;

    typedef enum logic [SEL_W-1:0] {
        SEL_QUES     = 3'h0,
        SEL_INTEG    = 3'h1,
        SEL_INTEG_HW = 3'h2,
        SEL_LIM1     = 3'h3,
        SEL_LIM2     = 3'h4
    } qst_sel_e;

    typedef enum logic [OP_W-1:0] {
        OP_NONE        = 4'h0,
        OP_READ_COND   = 4'h1,
        OP_READ_EVENT  = 4'h2,
        OP_READ_ENABLE = 4'h3,
        OP_READ_PTR    = 4'h4,
        OP_READ_NTR    = 4'h5,
        OP_WRITE_ENA   = 4'h6,
        OP_WRITE_PTR   = 4'h7,
        OP_WRITE_NTR   = 4'h8,
        OP_PRESET      = 4'h9,
        OP_CLEAR_STAT  = 4'hA,
        OP_INSTR_RESET = 4'hB,
        OP_QUEUE_NEXT  = 4'hC,
        OP_WRITE_OPER  = 4'hD,
        OP_WRITE_QENA  = 4'hE
    } qst_op_e;

    // A select code names one of the five registers
    function automatic logic qst_sel_ok(input logic [SEL_W-1:0] sel);
        qst_sel_ok = (sel <= SEL_LIM2);
    endfunction : qst_sel_ok

    // Places a single summary bit at its position in a parent register
    function automatic logic [REG_W-1:0] qst_bit_at(input logic b, input int pos);
        qst_bit_at = ALL_ZEROS;
        qst_bit_at[pos] = b;
    endfunction : qst_bit_at

endpackage : qst_pkg

// ===== src/qst_status_reg.sv
// One status register: condition edge filters, event latch, enable mask, summary
`timescale 1ns/1ps
`default_nettype none
module qst_status_reg
    import qst_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [REG_W-1:0] cond_i,
    input  wire logic [REG_W-1:0] wdata_i,
    input  wire logic             wr_ena_i,
    input  wire logic             wr_ptr_i,
    input  wire logic             wr_ntr_i,
    input  wire logic             preset_i,
    input  wire logic             evt_clr_i,
    output logic      [REG_W-1:0] evt_o,
    output logic      [REG_W-1:0] ena_o,
    output logic      [REG_W-1:0] ptr_o,
    output logic      [REG_W-1:0] ntr_o,
    output logic      [REG_W-1:0] set_o,
    output logic                  sum_o
);
    typedef struct packed {
        logic [REG_W-1:0] prev;
        logic [REG_W-1:0] evt;
        logic [REG_W-1:0] ena;
        logic [REG_W-1:0] ptr;
        logic [REG_W-1:0] ntr;
        logic             sum;
    } qst_sreg_s;

    qst_sreg_s s_q;
    qst_sreg_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev = cond_i;
        set_o = ((cond_i & ~s_q.prev) & s_q.ptr) | ((~cond_i & s_q.prev) & s_q.ntr); // R10 R11
        // New edges survive a clear in the same cycle
        s_d.evt = (evt_clr_i ? ALL_ZEROS : s_q.evt) | set_o; // R9
        s_d.sum = |(s_q.evt & s_q.ena); // R17
        if (preset_i) begin
            s_d.ena = ALL_ONES; // R3
            s_d.ptr = ALL_ONES; // R4
            s_d.ntr = ALL_ZEROS; // R4
        end
        if (wr_ena_i) begin
            s_d.ena = wdata_i; // R8
        end
        if (wr_ptr_i) begin
            s_d.ptr = wdata_i; // R8
        end
        if (wr_ntr_i) begin
            s_d.ntr = wdata_i; // R8
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '{prev: ALL_ZEROS, evt: ALL_ZEROS, ena: ENA_RST, ptr: PTR_RST, ntr: NTR_RST, sum: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign evt_o = s_q.evt;
    assign ena_o = s_q.ena;
    assign ptr_o = s_q.ptr;
    assign ntr_o = s_q.ntr;
    assign sum_o = s_q.sum;

endmodule : qst_status_reg
`default_nettype wire

// ===== src/qst_error_queue.sv
// Error queue: oldest-first store of error number and description code
`timescale 1ns/1ps
`default_nettype none
module qst_error_queue
    import qst_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        reset_i,
    input  wire logic                        enable_i,
    input  wire logic                        push_i,
    input  wire logic signed [ERR_NUM_W-1:0] push_num_i,
    input  wire logic [ERR_DESC_W-1:0]       push_desc_i,
    input  wire logic                        pop_i,
    input  wire logic                        clear_i,
    output logic signed [ERR_NUM_W-1:0]      head_num_o,
    output logic [ERR_DESC_W-1:0]            head_desc_o,
    output logic [QUEUE_CNT_W-1:0]           count_o
);
    typedef struct packed {
        logic [QUEUE_DEPTH-1:0][ENTRY_W-1:0] mem;
        logic [QUEUE_PTR_W-1:0]              rd;
        logic [QUEUE_PTR_W-1:0]              wr;
        logic [QUEUE_CNT_W-1:0]              cnt;
    } qst_queue_s;

    qst_queue_s s_q;
    qst_queue_s s_d;
    logic       pop_w;
    logic       push_w;

    always_comb begin
        s_d = s_q;
        pop_w = pop_i && (s_q.cnt != QCNT_ZERO); // R12
        // A full queue drops new entries unless one is popped now, even when a clear empties it
        push_w = push_i && enable_i && ((s_q.cnt != QCNT_FULL) || pop_w);
        if (clear_i) begin
            s_d.rd = QPTR_ZERO;
            s_d.wr = QPTR_ZERO;
            s_d.cnt = QCNT_ZERO;
        end else if (pop_w) begin
            s_d.rd = s_q.rd + QPTR_ONE;
            s_d.cnt = s_q.cnt - QCNT_ONE;
        end
        if (push_w) begin
            s_d.mem[s_d.wr] = {push_num_i, push_desc_i}; // R13
            s_d.wr = s_d.wr + QPTR_ONE;
            s_d.cnt = s_d.cnt + QCNT_ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '{mem: '0, rd: QPTR_ZERO, wr: QPTR_ZERO, cnt: QCNT_ZERO};
        end else begin
            s_q <= s_d;
        end
    end

    assign head_num_o  = (s_q.cnt == QCNT_ZERO) ? NO_ERROR_NUM : s_q.mem[s_q.rd][ENTRY_W-1:ERR_DESC_W]; // R14
    assign head_desc_o = (s_q.cnt == QCNT_ZERO) ? NO_ERROR_DESC : s_q.mem[s_q.rd][ERR_DESC_W-1:0]; // R14
    assign count_o     = s_q.cnt;

endmodule : qst_error_queue
`default_nettype wire

// ===== src/qst_status_tree.sv
// Questionable status tree: five status registers, command decode and error queue
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Instrument reset command leaves all status registers untouched; clear-status clears their event parts and the error queue.
// R2 - Preset touches only filters, enable masks and queue enabling, never condition or event.
// R3 - Preset loads operation and all questionable-family enable masks with all ones.
// R4 - Preset sets positive filters to all ones, negative filters to all zeros.
// R5 - Condition reads return live bits and change nothing.
// R6 - An enabled event bit turning true raises the summary bit in the parent.
// R7 - First limit register feeds questionable bit 10; second feeds first limit bit 0.
// R8 - Enable masks and filters take any 16-bit value.
// R9 - Event reads return the latched bits and clear that event register.
// R10 - Negative filter bit set: condition one-to-zero sets the event bit.
// R11 - Positive filter bit set: condition zero-to-one sets the event bit.
// R12 - Next-entry query returns the oldest queue entry and removes it.
// R13 - Queue entries hold a signed error number and a description code.
// R14 - Empty queue answers error number zero with the no-error description.
// R15 - Two separate limit registers, each complete, chosen by select code.
// R16 - Each of the five registers has its own readable event part.
// R17 - Summary is the OR over all bits of event AND enable.
module qst_status_tree
    import qst_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        reset_i,
    input  wire logic                        cmd_valid_i,
    input  wire logic [OP_W-1:0]             cmd_op_i,
    input  wire logic [SEL_W-1:0]            cmd_sel_i,
    input  wire logic [REG_W-1:0]            cmd_data_i,
    input  wire logic [REG_W-1:0]            ques_cond_i,
    input  wire logic [REG_W-1:0]            integ_cond_i,
    input  wire logic [REG_W-1:0]            integ_hw_cond_i,
    input  wire logic [REG_W-1:0]            lim1_cond_i,
    input  wire logic [REG_W-1:0]            lim2_cond_i,
    input  wire logic                        err_push_i,
    input  wire logic signed [ERR_NUM_W-1:0] err_num_i,
    input  wire logic [ERR_DESC_W-1:0]       err_desc_i,
    output logic                             rsp_valid_o,
    output logic [REG_W-1:0]                 rsp_data_o,
    output logic signed [ERR_NUM_W-1:0]      rsp_err_num_o,
    output logic [ERR_DESC_W-1:0]            rsp_err_desc_o,
    output logic                             ques_summary_o,
    output logic [REG_W-1:0]                 oper_enable_o,
    output logic                             queue_enable_o
);
    typedef struct packed {
        logic                        rsp_valid;
        logic [REG_W-1:0]            rsp_data;
        logic signed [ERR_NUM_W-1:0] rsp_err_num;
        logic [ERR_DESC_W-1:0]       rsp_err_desc;
        logic                        ques_sum;
        logic [REG_W-1:0]            oper_ena;
        logic                        queue_ena;
    } qst_top_s;

    qst_top_s s_q;
    qst_top_s s_d;

    qst_op_e                             op_w;
    logic                                sel_ok_w;
    logic [NUM_REGS-1:0][REG_W-1:0]      cond_eff;
    logic [NUM_REGS-1:0][REG_W-1:0]      evt_w;
    logic [NUM_REGS-1:0][REG_W-1:0]      ena_w;
    logic [NUM_REGS-1:0][REG_W-1:0]      ptr_w;
    logic [NUM_REGS-1:0][REG_W-1:0]      ntr_w;
    logic [NUM_REGS-1:0][REG_W-1:0]      set_w;
    logic [NUM_REGS-1:0]                 sum_w;
    logic [NUM_REGS-1:0]                 wr_ena_w;
    logic [NUM_REGS-1:0]                 wr_ptr_w;
    logic [NUM_REGS-1:0]                 wr_ntr_w;
    logic [NUM_REGS-1:0]                 evt_clr_w;
    logic                                preset_w;
    logic                                clear_w;
    logic                                pop_w;
    logic                                rd_cond_w;
    logic                                rd_evt_w;
    logic                                instr_rst_w;
    logic signed [ERR_NUM_W-1:0]         head_num_w;
    logic [ERR_DESC_W-1:0]               head_desc_w;
    logic [QUEUE_CNT_W-1:0]              q_count_w;

    assign op_w        = qst_op_e'(cmd_op_i);
    assign sel_ok_w    = qst_sel_ok(cmd_sel_i);
    assign preset_w    = cmd_valid_i && (op_w == OP_PRESET);
    assign clear_w     = cmd_valid_i && (op_w == OP_CLEAR_STAT); // R1
    assign pop_w       = cmd_valid_i && (op_w == OP_QUEUE_NEXT); // R12
    assign rd_cond_w   = cmd_valid_i && (op_w == OP_READ_COND);
    assign rd_evt_w    = cmd_valid_i && (op_w == OP_READ_EVENT);
    assign instr_rst_w = cmd_valid_i && (op_w == OP_INSTR_RESET);

    // Child summaries merge into the parent condition bits
    assign cond_eff[SEL_QUES]     = ques_cond_i
                                  | qst_bit_at(sum_w[SEL_INTEG], INTEG_SUM_BIT)
                                  | qst_bit_at(sum_w[SEL_LIM1], LIM1_SUM_BIT); // R7
    assign cond_eff[SEL_INTEG]    = integ_cond_i | qst_bit_at(sum_w[SEL_INTEG_HW], INTEG_HW_SUM_BIT); // R6
    assign cond_eff[SEL_INTEG_HW] = integ_hw_cond_i;
    assign cond_eff[SEL_LIM1]     = lim1_cond_i | qst_bit_at(sum_w[SEL_LIM2], LIM2_SUM_BIT); // R7
    assign cond_eff[SEL_LIM2]     = lim2_cond_i;

    for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
        logic sel_hit;
        assign sel_hit      = cmd_valid_i && (cmd_sel_i == SEL_W'(k)); // R15 R16
        assign wr_ena_w[k]  = sel_hit && (op_w == OP_WRITE_ENA);
        assign wr_ptr_w[k]  = sel_hit && (op_w == OP_WRITE_PTR);
        assign wr_ntr_w[k]  = sel_hit && (op_w == OP_WRITE_NTR);
        assign evt_clr_w[k] = (sel_hit && (op_w == OP_READ_EVENT)) || clear_w; // R9 R1

        qst_status_reg u_reg (
            .clk_i     (clk_i),
            .reset_i   (reset_i),
            .cond_i    (cond_eff[k]),
            .wdata_i   (cmd_data_i),
            .wr_ena_i  (wr_ena_w[k]),
            .wr_ptr_i  (wr_ptr_w[k]),
            .wr_ntr_i  (wr_ntr_w[k]),
            .preset_i  (preset_w),
            .evt_clr_i (evt_clr_w[k]),
            .evt_o     (evt_w[k]),
            .ena_o     (ena_w[k]),
            .ptr_o     (ptr_w[k]),
            .ntr_o     (ntr_w[k]),
            .set_o     (set_w[k]),
            .sum_o     (sum_w[k])
        );
    end

    qst_error_queue u_queue (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .enable_i    (s_q.queue_ena),
        .push_i      (err_push_i),
        .push_num_i  (err_num_i),
        .push_desc_i (err_desc_i),
        .pop_i       (pop_w),
        .clear_i     (clear_w),
        .head_num_o  (head_num_w),
        .head_desc_o (head_desc_w),
        .count_o     (q_count_w)
    );

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.ques_sum = sum_w[SEL_QUES];
        if (cmd_valid_i) begin
            s_d.rsp_valid = 1'b1;
            unique case (op_w)
                OP_NONE: begin
                    s_d.rsp_valid = 1'b0;
                end
                OP_READ_COND: begin
                    s_d.rsp_data = sel_ok_w ? cond_eff[cmd_sel_i] : ALL_ZEROS; // R5
                end
                OP_READ_EVENT: begin
                    s_d.rsp_data = sel_ok_w ? evt_w[cmd_sel_i] : ALL_ZEROS; // R9
                end
                OP_READ_ENABLE: begin
                    s_d.rsp_data = sel_ok_w ? ena_w[cmd_sel_i] : ALL_ZEROS;
                end
                OP_READ_PTR: begin
                    s_d.rsp_data = sel_ok_w ? ptr_w[cmd_sel_i] : ALL_ZEROS;
                end
                OP_READ_NTR: begin
                    s_d.rsp_data = sel_ok_w ? ntr_w[cmd_sel_i] : ALL_ZEROS;
                end
                OP_WRITE_ENA, OP_WRITE_PTR, OP_WRITE_NTR, OP_CLEAR_STAT: begin
                end
                OP_PRESET: begin
                    s_d.oper_ena = ALL_ONES; // R3
                    s_d.queue_ena = 1'b1; // R2
                end
                OP_INSTR_RESET: begin
                end
                OP_QUEUE_NEXT: begin
                    s_d.rsp_err_num = head_num_w; // R12 R14
                    s_d.rsp_err_desc = head_desc_w; // R13
                end
                OP_WRITE_OPER: begin
                    s_d.oper_ena = cmd_data_i; // R8
                end
                OP_WRITE_QENA: begin
                    s_d.queue_ena = cmd_data_i[0];
                end
                default: begin
                    s_d.rsp_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '{rsp_valid: 1'b0, rsp_data: ALL_ZEROS, rsp_err_num: NO_ERROR_NUM,
                     rsp_err_desc: NO_ERROR_DESC, ques_sum: 1'b0, oper_ena: OPER_RST, queue_ena: QENA_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_valid_o    = s_q.rsp_valid;
    assign rsp_data_o     = s_q.rsp_data;
    assign rsp_err_num_o  = s_q.rsp_err_num;
    assign rsp_err_desc_o = s_q.rsp_err_desc;
    assign ques_summary_o = s_q.ques_sum;
    assign oper_enable_o  = s_q.oper_ena;
    assign queue_enable_o = s_q.queue_ena;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_RST_KEEPS_STATUS: assert property ( // R1
        instr_rst_w |=> ((evt_w & $past(evt_w)) == $past(evt_w)) && (ena_w == $past(ena_w))
                        && (ptr_w == $past(ptr_w)) && (ntr_w == $past(ntr_w)))
        else $error("Instrument reset changed status contents");

    AST_CLEAR_STATUS: assert property ( // R1
        clear_w |=> (evt_w == $past(set_w)) && (q_count_w == QCNT_ZERO || $past(err_push_i)))
        else $error("Clear status left events or queue entries");

    AST_PRESET_KEEPS_EVENTS: assert property ( // R2
        preset_w |=> evt_w == ($past(evt_w) | $past(set_w)))
        else $error("Preset changed event contents");

    AST_PRESET_ENABLES: assert property ( // R3
        preset_w |=> (ena_w == {NUM_REGS{ALL_ONES}}) && (oper_enable_o == ALL_ONES) && queue_enable_o)
        else $error("Preset did not set enable masks to ones");

    AST_PRESET_FILTERS: assert property ( // R4
        preset_w |=> (ptr_w == {NUM_REGS{ALL_ONES}}) && (ntr_w == {NUM_REGS{ALL_ZEROS}}))
        else $error("Preset left transition filters wrong");

    AST_COND_READ: assert property ( // R5
        rd_cond_w && sel_ok_w |=> rsp_valid_o && (rsp_data_o == $past(cond_eff[cmd_sel_i]))
                                  && (($past(evt_w) & ~evt_w) == '0))
        else $error("Condition read wrong or destructive");

    AST_ENABLED_EVENT_SUMMARY: assert property ( // R6 R17
        ((evt_w[SEL_LIM1] & ena_w[SEL_LIM1]) != ALL_ZEROS) |=> sum_w[SEL_LIM1])
        else $error("Enabled event did not raise summary");

    AST_SUMMARY_CLEAR: assert property ( // R17
        ((evt_w[SEL_QUES] & ena_w[SEL_QUES]) == ALL_ZEROS) |=> ##1 !ques_summary_o)
        else $error("Summary high with no enabled event");

    AST_LIM2_INTO_LIM1: assert property ( // R7
        $rose(sum_w[SEL_LIM2]) && !$past(lim1_cond_i[LIM2_SUM_BIT]) && ptr_w[SEL_LIM1][LIM2_SUM_BIT]
        |=> evt_w[SEL_LIM1][LIM2_SUM_BIT])
        else $error("Second limit summary not latched in first limit bit 0");

    AST_LIM1_INTO_QUES: assert property ( // R7
        sum_w[SEL_LIM1] |-> cond_eff[SEL_QUES][LIM1_SUM_BIT])
        else $error("First limit summary missing from questionable bit 10");

    AST_FULL_RANGE_WRITE: assert property ( // R8
        (|wr_ena_w) |=> ena_w[$past(cmd_sel_i)] == $past(cmd_data_i))
        else $error("Enable mask write not taken in full");

    AST_EVENT_READ_CLEARS: assert property ( // R9 R16
        rd_evt_w && sel_ok_w |=> (rsp_data_o == $past(evt_w[cmd_sel_i]))
                                 && (evt_w[$past(cmd_sel_i)] == $past(set_w[cmd_sel_i])))
        else $error("Event read wrong or not cleared");

    AST_NEG_TRANSITION: assert property ( // R10
        !$past(reset_i) && !$past(reset_i, 2) |->
            ((($past(cond_eff[SEL_LIM2], 2) & ~$past(cond_eff[SEL_LIM2])) & $past(ntr_w[SEL_LIM2]))
             & ~evt_w[SEL_LIM2]) == ALL_ZEROS)
        else $error("Falling condition edge not latched");

    AST_POS_TRANSITION: assert property ( // R11
        !$past(reset_i) && !$past(reset_i, 2) |->
            (((~$past(cond_eff[SEL_QUES], 2) & $past(cond_eff[SEL_QUES])) & $past(ptr_w[SEL_QUES]))
             & ~evt_w[SEL_QUES]) == ALL_ZEROS)
        else $error("Rising condition edge not latched");

    AST_QUEUE_POP: assert property ( // R12
        pop_w && (q_count_w != QCNT_ZERO) && !err_push_i |=>
            (rsp_err_num_o == $past(head_num_w)) && (q_count_w == $past(q_count_w) - QCNT_ONE))
        else $error("Next-entry query did not remove oldest entry");

    AST_QUEUE_ENTRY: assert property ( // R13
        err_push_i && queue_enable_o && (q_count_w == QCNT_ZERO) && !pop_w && !clear_w |=>
            (head_num_w == $past(err_num_i)) && (head_desc_w == $past(err_desc_i)))
        else $error("Queue entry not stored as given");

    AST_QUEUE_EMPTY: assert property ( // R14
        pop_w && (q_count_w == QCNT_ZERO) |=>
            (rsp_err_num_o == NO_ERROR_NUM) && (rsp_err_desc_o == NO_ERROR_DESC))
        else $error("Empty queue did not answer no error");

    AST_HW_INTO_INTEG: assert property ( // R6
        sum_w[SEL_INTEG_HW]
        |-> cond_eff[SEL_INTEG][INTEG_HW_SUM_BIT])
        else $error("Integrity_hw_reg summary lost");

    AST_INTEG_INTO_QUES: assert property ( // R6
        sum_w[SEL_INTEG]
        |-> cond_eff[SEL_QUES][INTEG_SUM_BIT])
        else $error("Integrity summary lost");

    AST_READ_ANSWERED: assert property ( // R5 R9 R12
        rd_cond_w || rd_evt_w || pop_w
        |=> rsp_valid_o)
        else $error("Query not answered");

    AST_BAD_SEL_EVT: assert property ( // R15
        rd_evt_w && !sel_ok_w
        |=> (rsp_data_o == ALL_ZEROS) && (evt_w == ($past(evt_w) | $past(set_w))))
        else $error("Bad select read touched events");

    AST_PRESET_KEEPS_QUEUE: assert property ( // R2
        preset_w && !err_push_i
        |=> q_count_w == $past(q_count_w))
        else $error("Preset changed error queue");

    AST_PTR_WRITE: assert property ( // R8
        (|wr_ptr_w)
        |=> ptr_w[$past(cmd_sel_i)] == $past(cmd_data_i))
        else $error("Positive filter write not taken");

    AST_NTR_WRITE: assert property ( // R8
        (|wr_ntr_w)
        |=> ntr_w[$past(cmd_sel_i)] == $past(cmd_data_i))
        else $error("Negative filter write not taken");

    AST_EVENT_HOLDS: assert property ( // R9
        !rd_evt_w && !clear_w
        |=> ($past(evt_w) & ~evt_w) == '0)
        else $error("Event bit lost without a read");

    AST_QUEUE_GATED: assert property ( // R2
        err_push_i && !queue_enable_o && !pop_w && !clear_w
        |=> q_count_w == $past(q_count_w))
        else $error("Disabled queue took an entry");

    COV_PRESET: cover property (preset_w ##1 rsp_valid_o);
    COV_EVENT_READ: cover property (rd_evt_w && (evt_w[SEL_LIM2] != ALL_ZEROS) && (cmd_sel_i == SEL_LIM2));
    COV_QUEUE_POP: cover property (pop_w && (q_count_w != QCNT_ZERO));
    COV_LIM2_CHAIN: cover property ($rose(sum_w[SEL_LIM2]) ##[1:4] $rose(ques_summary_o));
    COV_QUEUE_OFF: cover property (err_push_i && !queue_enable_o);

endmodule : qst_status_tree
`default_nettype wire

// ===== dv/qst_status_tree_tb_top.sv
// Self-checking bench of the questionable status tree
`timescale 1ns/1ps
`default_nettype none
module qst_status_tree_tb_top
    import qst_pkg::*;
;
    logic                        clk_i = 1'b0;
    logic                        reset_i = 1'b1;
    logic                        v = 1'b0;
    logic                        push = 1'b0;
    logic [OP_W-1:0]             op = OP_NONE;
    logic [SEL_W-1:0]            sel = 3'h0;
    logic [REG_W-1:0]            dat = 16'h0000;
    logic [REG_W-1:0]            c1 = 16'h0000;
    logic [REG_W-1:0]            c3 = 16'h0000;
    logic [REG_W-1:0]            c4 = 16'h0000;
    logic signed [ERR_NUM_W-1:0] en = 16'sh0000;
    logic [ERR_DESC_W-1:0]       ed = 8'h00;
    logic                        rv;
    logic [REG_W-1:0]            rdat;
    logic signed [ERR_NUM_W-1:0] rn;
    logic [ERR_DESC_W-1:0]       rdesc;
    logic                        qs;
    logic [REG_W-1:0]            oe;
    logic                        qe;
    int                          err_count = 0;
    int                          checks_done = 0;
    int                          cyc = 0;

    always #10 clk_i = ~clk_i;

    qst_status_tree dut_u (.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(v), .cmd_op_i(op), .cmd_sel_i(sel),
        .cmd_data_i(dat), .ques_cond_i(c1), .integ_cond_i(c1), .integ_hw_cond_i(c4),
        .lim1_cond_i(c3), .lim2_cond_i(c4), .err_push_i(push), .err_num_i(en), .err_desc_i(ed),
        .rsp_valid_o(rv), .rsp_data_o(rdat), .rsp_err_num_o(rn), .rsp_err_desc_o(rdesc),
        .ques_summary_o(qs), .oper_enable_o(oe), .queue_enable_o(qe));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cmd(input logic [OP_W-1:0] o, input logic [SEL_W-1:0] s, input logic [REG_W-1:0] d);
        @(posedge clk_i); #1;
        v = 1'b1; op = o; sel = s; dat = d;
        @(posedge clk_i); #1;
        v = 1'b0;
        chk("rsp_valid", {15'h0000, rv}, 16'h0001);
    endtask : cmd

    task automatic rd(input logic [OP_W-1:0] o, input logic [SEL_W-1:0] s, input logic [REG_W-1:0] exp);
        cmd(o, s, 16'h0000);
        chk("rsp_data", rdat, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    task automatic put(input logic signed [ERR_NUM_W-1:0] n, input logic [ERR_DESC_W-1:0] d);
        @(posedge clk_i); #1;
        push = 1'b1; en = n; ed = d;
        @(posedge clk_i); #1;
        push = 1'b0;
    endtask : put

    task automatic nxt(input logic [REG_W-1:0] n, input logic [ERR_DESC_W-1:0] d);
        cmd(OP_QUEUE_NEXT, SEL_QUES, 16'h0000);
        chk("err_num", rn, n);
        chk("err_desc", {8'h00, rdesc}, {8'h00, d});
    endtask : nxt

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_i = 1'b0;
        for (int i = 0; i < 5; i++) cmd(OP_WRITE_NTR, i[2:0], 16'hFFFF >> i);
        for (int i = 0; i < 5; i++) rd(OP_READ_NTR, i[2:0], 16'hFFFF >> i);
        cmd(OP_WRITE_ENA, SEL_LIM2, 16'h0006);
        rd(OP_READ_ENABLE, SEL_LIM2, 16'h0006);
        rd(OP_READ_EVENT, 3'h7, 16'h0000);
        $display("test filter range done");
        c3 = 16'h0008;
        idle(2);
        rd(OP_READ_COND, SEL_LIM1, 16'h0008);
        rd(OP_READ_COND, SEL_LIM1, 16'h0008);
        rd(OP_READ_EVENT, SEL_LIM1, 16'h0008);
        rd(OP_READ_EVENT, SEL_LIM1, 16'h0000);
        c3 = 16'h0000;
        idle(2);
        rd(OP_READ_EVENT, SEL_LIM1, 16'h0008);
        cmd(OP_WRITE_PTR, SEL_LIM1, 16'h0000);
        c3 = 16'h0008;
        idle(2);
        rd(OP_READ_EVENT, SEL_LIM1, 16'h0000);
        $display("test edges done");
        c4 = 16'h0001;
        idle(2);
        cmd(OP_INSTR_RESET, SEL_QUES, 16'h0000);
        rd(OP_READ_PTR, SEL_LIM1, 16'h0000);
        cmd(OP_WRITE_OPER, SEL_QUES, 16'h1234);
        chk("oper_enable", oe, 16'h1234);
        cmd(OP_WRITE_QENA, SEL_QUES, 16'h0000);
        put(16'sd3, 8'h33);
        nxt(16'h0000, NO_ERROR_DESC);
        cmd(OP_PRESET, SEL_QUES, 16'h0000);
        chk("oper_enable", oe, 16'hFFFF);
        chk("queue_enable", {15'h0000, qe}, 16'h0001);
        rd(OP_READ_ENABLE, SEL_INTEG, 16'hFFFF);
        rd(OP_READ_PTR, SEL_LIM1, 16'hFFFF);
        rd(OP_READ_NTR, SEL_QUES, 16'h0000);
        idle(8);
        chk("ques_summary", {15'h0000, qs}, 16'h0001);
        rd(OP_READ_EVENT, SEL_LIM2, 16'h0001);
        rd(OP_READ_EVENT, SEL_LIM1, 16'h0001);
        rd(OP_READ_EVENT, SEL_QUES, 16'h0600);
        idle(4);
        chk("ques_summary", {15'h0000, qs}, 16'h0000);
        c1 = 16'h0020;
        idle(2);
        cmd(OP_CLEAR_STAT, SEL_QUES, 16'h0000);
        rd(OP_READ_EVENT, SEL_INTEG, 16'h0000);
        rd(OP_READ_COND, SEL_QUES, 16'h0020);
        $display("test tree done");
        nxt(16'h0000, NO_ERROR_DESC);
        put(-16'sd5, 8'h11);
        put(16'sd7, 8'h22);
        nxt(16'hFFFB, 8'h11);
        nxt(16'h0007, 8'h22);
        nxt(16'h0000, NO_ERROR_DESC);
        $display("test queue done");
        end_sim();
    end
endmodule : qst_status_tree_tb_top
`default_nettype wire
